// file: core/tec_counter.sv
// Operation
// - 8-bit up-counter, selectable count clock
// - Time base: system or crystal option
// - Tone frequency from prescaled clock and preload
// - Data at 0DH, control at 0EH
// - Write goes preload, read gives counter
// - Event mode counts pin transitions
// - Timer mode counts prescaled internal clock
// - Overflow reloads and sets request flag
// - Pulse mode: edge starts, return stops, clears run
// - Pulse mode counts prescaled internal clock
// - Edge select picks starting edge polarity
// - One measurement, then wait for run
// - Pulse mode starts on edges only
// - Pulse mode overflow reloads and flags
// - Counts only while run bit set
// - Event/timer modes never self-clear run
// - Overflow is a halt wake-up source
// - Enable bit zero suppresses interrupt service
// - Reset control to 00-0 1000
// - Warm reset leaves counter registers alone
// - Mode bits 7:6 decode
// - Prescale code 000 is /2, doubling
// - Stopped write loads counter too
// - Reading data blocks the count clock
`timescale 1ns/1ps
module tec_counter
  import tec_pkg::*;
#(
  parameter bit USE_XTAL = 1'b0
)
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_warm_rst,
  input  wire logic       i_bus_wr,
  input  wire logic       i_bus_rd,
  input  wire logic [7:0] i_bus_addr,
  input  wire logic [7:0] i_bus_wdata,
  input  wire logic       i_flag_clr,
  input  wire logic       i_irq_enable,
  input  wire logic       i_count_pin,
  input  wire logic       i_xtal_clk,
  output logic      [7:0] o_bus_rdata,
  output logic            o_overflow_request_flag,
  output logic            o_irq,
  output logic            o_wake,
  output logic            o_divided_tone_output
);

  tec_state_s s_q;
  tec_state_s s_d;
  tec_bus_s   bus;
  tec_mode_e  mode;
  logic [2:0] psc;
  logic       run;
  logic       edge_sel;
  logic       base_tick;
  logic       int_tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       start_edge;
  logic       stop_edge;
  logic       tick;
  logic       ovf;
  logic       irq_q;
  logic       wr_value;
  logic       wr_ctrl;
  logic       rd_value;

  // Prescaler tap for code: /2 at 000 up to /256 at 111
  function automatic logic presc_tap(input logic [7:0] cnt, input logic [2:0] code);
    presc_tap = cnt[code];
  endfunction

  // Strobed address match; shared by the write and read decodes
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  assign bus        = '{wr: i_bus_wr, rd: i_bus_rd, addr: i_bus_addr, wdata: i_bus_wdata};
  assign wr_value   = addr_hit(bus.wr, bus.addr, TEC_ADDR_VALUE);
  assign wr_ctrl    = addr_hit(bus.wr, bus.addr, TEC_ADDR_CONTROL);
  assign rd_value   = addr_hit(bus.rd, bus.addr, TEC_ADDR_VALUE);
  assign mode       = tec_mode_e'(s_q.ctrl[TEC_BIT_MODE_LO +: 2]);
  assign psc        = s_q.ctrl[TEC_BIT_PSC_LO +: 3];
  assign run        = s_q.ctrl[TEC_BIT_RUN];
  assign edge_sel   = s_q.ctrl[TEC_BIT_EDGE];
  assign pin_rise   = s_q.pin_s2 & ~s_q.pin_s3;
  assign pin_fall   = ~s_q.pin_s2 & s_q.pin_s3;
  // Edge select 1 starts on rising edge; the control table reads inverted
  assign start_edge = edge_sel ? pin_rise : pin_fall;
  assign stop_edge  = edge_sel ? pin_fall : pin_rise;
  // Crystal edge gates prescaler when that time base is built in
  assign base_tick  = USE_XTAL ? (s_q.xtal_s2 & ~s_q.xtal_s3) : 1'b1;

  always_comb
  begin
    logic [7:0] np;
    np       = s_q.presc + 8'h01;
    int_tick = base_tick && (np[psc] & ~presc_tap(s_q.presc, psc));
    case (mode)
      TEC_MODE_EVENT: tick = pin_rise | pin_fall;
      TEC_MODE_TIMER: tick = int_tick;
      TEC_MODE_PULSE: tick = int_tick && (s_q.pw == TEC_PW_MEAS);
      default:        tick = 1'b0;
    endcase
    // Reads freeze the count; one tick may be lost
    tick = tick && run && !rd_value;
    ovf  = tick && (s_q.count == TEC_COUNT_MAX);
  end

  always_comb
  begin
    s_d         = s_q;
    s_d.pin_s1  = i_count_pin;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.pin_s3  = s_q.pin_s2;
    s_d.xtal_s1 = i_xtal_clk;
    s_d.xtal_s2 = s_q.xtal_s1;
    s_d.xtal_s3 = s_q.xtal_s2;
    s_d.wake    = ovf;
    if (base_tick)
    begin
      s_d.presc = s_q.presc + 8'h01;
    end
    if (tick)
    begin
      s_d.count = ovf ? s_q.preload : s_q.count + 8'h01;
    end
    if (ovf)
    begin
      s_d.tone = ~s_q.tone;
    end
    // Set wins over a simultaneous clear
    if (i_flag_clr)
    begin
      s_d.flag = 1'b0;
    end
    if (ovf)
    begin
      s_d.flag = 1'b1;
    end
    case (s_q.pw)
      TEC_PW_IDLE:
      begin
        if (mode == TEC_MODE_PULSE && run && start_edge)
        begin
          s_d.pw = TEC_PW_MEAS;
        end
      end
      TEC_PW_MEAS:
      begin
        if (mode != TEC_MODE_PULSE)
        begin
          s_d.pw = TEC_PW_IDLE;
        end
        else if (stop_edge)
        begin
          s_d.pw = TEC_PW_DONE;
          s_d.ctrl[TEC_BIT_RUN] = 1'b0;
        end
      end
      TEC_PW_DONE:
      begin
        if (run)
        begin
          s_d.pw = TEC_PW_IDLE;
        end
      end
      default: s_d.pw = TEC_PW_IDLE;
    endcase
    if (wr_value)
    begin
      s_d.preload = bus.wdata;
      if (!run)
      begin
        s_d.count = bus.wdata;
      end
    end
    if (wr_ctrl)
    begin
      s_d.ctrl = bus.wdata & TEC_CTRL_WMASK;
    end
    case (bus.addr)
      TEC_ADDR_VALUE:   s_d.rdata = s_q.count;
      TEC_ADDR_CONTROL: s_d.rdata = s_q.ctrl;
      default:          s_d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      // Counter data is undefined on the pins; zero keeps runs clean
      s_q.count   <= 8'h00;
      s_q.preload <= 8'h00;
      s_q.ctrl    <= TEC_CTRL_RESET;
      s_q.presc   <= 8'h00;
      s_q.rdata   <= 8'h00;
      s_q.flag    <= 1'b0;
      s_q.tone    <= 1'b0;
      s_q.wake    <= 1'b0;
      // Idle pin level is low, so no false edge after reset
      s_q.pin_s1  <= 1'b0;
      s_q.pin_s2  <= 1'b0;
      s_q.pin_s3  <= 1'b0;
      s_q.xtal_s1 <= 1'b0;
      s_q.xtal_s2 <= 1'b0;
      s_q.xtal_s3 <= 1'b0;
      s_q.pw      <= TEC_PW_IDLE;
      irq_q       <= 1'b0;
    end
    else if (!i_warm_rst)
    begin
      s_q   <= s_d;
      irq_q <= s_d.flag & i_irq_enable;
    end
    // Warm reset holds all state as it was
    else
    begin
      s_q <= s_q;
    end
  end

  assign o_bus_rdata             = s_q.rdata;
  assign o_overflow_request_flag = s_q.flag;
  assign o_irq                   = irq_q;
  assign o_wake                  = s_q.wake;
  assign o_divided_tone_output   = s_q.tone;

  a_ovf_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ovf && !i_warm_rst) |=> s_q.flag)
    else $error("overflow did not set flag");
  a_ovf_reload: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ovf && !i_warm_rst && !bus.wr) |=> s_q.count == $past(s_q.preload))
    else $error("overflow did not reload");
  a_no_run_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!run && !bus.wr) |=> $stable(s_q.count))
    else $error("count moved while stopped");
  a_tone_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ovf && !i_warm_rst) |=> s_q.tone != $past(s_q.tone))
    else $error("tone did not toggle");
  a_run_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run && mode != TEC_MODE_PULSE && !bus.wr) |=> run)
    else $error("run cleared by itself");
  a_pw_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.pw == TEC_PW_MEAS && mode == TEC_MODE_PULSE && stop_edge && !i_warm_rst
     && !bus.wr) |=> !run && s_q.pw == TEC_PW_DONE)
    else $error("pulse stop failed");
  a_read_block: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bus.rd && bus.addr == TEC_ADDR_VALUE && !bus.wr) |=> $stable(s_q.count))
    else $error("count moved during read");
  a_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_irq_enable |=> !o_irq || $past(i_warm_rst))
    else $error("irq while disabled");
  a_stop_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!run && bus.wr && bus.addr == TEC_ADDR_VALUE && !i_warm_rst)
    |=> s_q.count == $past(bus.wdata) && s_q.preload == $past(bus.wdata))
    else $error("stopped write missed counter");
  a_wake_on_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ovf && !i_warm_rst) |=> o_wake)
    else $error("overflow did not wake");
  a_wake_only_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!ovf && !i_warm_rst) |=> !o_wake)
    else $error("wake without overflow");
  a_warm_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_warm_rst |=> $stable(s_q))
    else $error("state moved in warm reset");
  a_ctrl_reset: assert property (@(posedge i_clk)
    i_sys_rst |=> s_q.ctrl == TEC_CTRL_RESET)
    else $error("control not reset");
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.flag && !i_flag_clr) |=> s_q.flag)
    else $error("flag cleared by itself");
  a_event_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode == TEC_MODE_EVENT && tick && !ovf && !bus.wr && !i_warm_rst)
    |=> s_q.count == $past(s_q.count) + 8'h01)
    else $error("event did not count");
  a_timer_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode == TEC_MODE_TIMER && tick && !ovf && !bus.wr && !i_warm_rst)
    |=> s_q.count == $past(s_q.count) + 8'h01)
    else $error("timer did not count");
  a_mode_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode == TEC_MODE_NONE && !bus.wr) |=> $stable(s_q.count))
    else $error("unused mode counted");
  a_pw_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.pw == TEC_PW_IDLE && mode == TEC_MODE_PULSE && run && start_edge
     && !i_warm_rst) |=> s_q.pw == TEC_PW_MEAS)
    else $error("pulse start missed");
  a_pw_done_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.pw == TEC_PW_DONE && !run && !bus.wr) |=> s_q.pw == TEC_PW_DONE)
    else $error("measurement restarted alone");
  a_irq_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_d.flag && i_irq_enable && !i_warm_rst) |=> o_irq)
    else $error("irq missing");
  a_rdata_unmap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_warm_rst && bus.addr != TEC_ADDR_VALUE && bus.addr != TEC_ADDR_CONTROL)
    |=> o_bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_run_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run && wr_value && !tick && !i_warm_rst) |=> $stable(s_q.count))
    else $error("running write hit counter");
  a_bit5_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !s_q.ctrl[5])
    else $error("unused control bit set");

  c_overflow:  cover property (@(posedge i_clk) ovf);
  c_pw_done:   cover property (@(posedge i_clk) s_q.pw == TEC_PW_DONE);
  c_event_ovf: cover property (@(posedge i_clk) ovf && mode == TEC_MODE_EVENT);
  c_warm_hold: cover property (@(posedge i_clk) i_warm_rst && run);
  c_timer_ovf: cover property (@(posedge i_clk) ovf && mode == TEC_MODE_TIMER);

endmodule

// file: core/tec_pkg.sv
package tec_pkg;

  localparam logic [7:0] TEC_ADDR_VALUE   = 8'h0d;
  localparam logic [7:0] TEC_ADDR_CONTROL = 8'h0e;
  localparam logic [7:0] TEC_CTRL_RESET   = 8'h08;
  localparam logic [7:0] TEC_CTRL_WMASK   = 8'hdf;
  localparam int         TEC_BIT_PSC_LO   = 0;
  localparam int         TEC_BIT_EDGE     = 3;
  localparam int         TEC_BIT_RUN      = 4;
  localparam int         TEC_BIT_MODE_LO  = 6;
  localparam logic [7:0] TEC_COUNT_MAX    = 8'hff;

  typedef enum logic [1:0]
  {
    TEC_MODE_NONE  = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_e;

  typedef enum logic [1:0]
  {
    TEC_PW_IDLE = 2'b00,
    TEC_PW_MEAS = 2'b01,
    TEC_PW_DONE = 2'b10
  } tec_pw_e;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tec_bus_s;

  typedef struct packed
  {
    logic [7:0] count;
    logic [7:0] preload;
    logic [7:0] ctrl;
    logic [7:0] presc;
    logic [7:0] rdata;
    logic       flag;
    logic       tone;
    logic       wake;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_s3;
    logic       xtal_s1;
    logic       xtal_s2;
    logic       xtal_s3;
    tec_pw_e    pw;
  } tec_state_s;

endpackage

// file: verification/tec_pin_model.sv
`timescale 1ns/1ps
module tec_pin_model
(
  input  wire logic i_clk,
  input  wire logic i_toggle,
  output logic      o_pin
);
  // Far-side source; level changes only when the bench commands it
  initial o_pin = 1'b0;
  always @(posedge i_clk)
    if (i_toggle)
      o_pin <= ~o_pin;
endmodule

// file: verification/test_timer_event_counter_8bit.sv
`timescale 1ns/1ps
module test_timer_event_counter_8bit;
  import tec_pkg::*;
  logic        clk, rst, wr, rd, fclr, ien, tog, pin, wrm;
  logic        flag, irq, wake, tone;
  logic [7:0]  addr, wdata, rdata, v;
  logic [31:0] rnd = 32'h82835c6e;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n;

  tec_counter uut (.i_clk(clk), .i_sys_rst(rst), .i_warm_rst(wrm), .i_bus_wr(wr),
    .i_bus_rd(rd), .i_bus_addr(addr), .i_bus_wdata(wdata), .i_flag_clr(fclr),
    .i_irq_enable(ien), .i_count_pin(pin), .i_xtal_clk(1'b0), .o_bus_rdata(rdata),
    .o_overflow_request_flag(flag), .o_irq(irq), .o_wake(wake),
    .o_divided_tone_output(tone));
  tec_pin_model far (.i_clk(clk), .i_toggle(tog), .o_pin(pin));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic br(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    q = rdata;
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic flip();
    @(negedge clk);
    tog = 1'b1;
    @(negedge clk);
    tog = 1'b0;
  endtask

  initial
  begin
    {wr, rd, fclr, ien, tog, wrm, addr, wdata} = '0;
    rst = 1'b1;
    idle(3);
    rst = 1'b0;
    br(TEC_ADDR_CONTROL, v);
    chk(v, TEC_CTRL_RESET);
    br(8'h0c, v);
    chk(v, 8'h00);
    bw(TEC_ADDR_CONTROL, 8'h27);
    br(TEC_ADDR_CONTROL, v);
    chk(v, 8'h07);
    rnd = lfsr(rnd);
    n = 1 + rnd[10:8];
    bw(TEC_ADDR_VALUE, {1'b0, rnd[6:0]});
    bw(TEC_ADDR_CONTROL, 8'h50);
    // Spacing drawn once from rnd, so every gap between pin flips is the same 6 to 9 cycles
    repeat (n)
    begin
      flip();
      idle(4 + rnd[13:12]);
    end
    idle(6);
    bw(TEC_ADDR_CONTROL, 8'h40);
    flip();
    idle(6);
    br(TEC_ADDR_VALUE, v);
    chk(v, 8'(rnd[6:0] + n));
    if (pin)
      flip();
    idle(6);
    bw(TEC_ADDR_CONTROL, 8'hc8);
    bw(TEC_ADDR_VALUE, 8'h00);
    bw(TEC_ADDR_CONTROL, 8'hd8);
    idle(4);
    // Second pulse must leave the first result untouched
    repeat (2)
    begin
      flip();
      idle(20);
      flip();
      idle(8);
      br(TEC_ADDR_VALUE, v);
      chk({7'h00, v inside {[8'h0a:8'h0c]}}, 8'h01);
      br(TEC_ADDR_CONTROL, v);
      chk(v, 8'hc8);
    end
    bw(TEC_ADDR_CONTROL, 8'h80);
    bw(TEC_ADDR_VALUE, 8'hfa);
    bw(TEC_ADDR_CONTROL, 8'h90);
    n = 0;
    while (flag !== 1'b1 && n < 100)
    begin
      idle(1);
      n++;
    end
    if (n == 100)
    begin
      bad_count++;
      results();
    end
    chk({7'h00, wake}, 8'h01);
    chk({7'h00, n >= 10 && n <= 15}, 8'h01);
    chk({7'h00, tone}, 8'h01);
    idle(1);
    chk({7'h00, irq}, 8'h00);
    ien = 1'b1;
    idle(2);
    chk({7'h00, irq}, 8'h01);
    br(TEC_ADDR_CONTROL, v);
    chk(v, 8'h90);
    // Stop first so no overflow can race the flag clear
    bw(TEC_ADDR_CONTROL, 8'h80);
    wrm = 1'b1;
    bw(TEC_ADDR_CONTROL, 8'h00);
    wrm = 1'b0;
    br(TEC_ADDR_CONTROL, v);
    chk(v, 8'h80);
    fclr = 1'b1;
    idle(1);
    fclr = 1'b0;
    chk({7'h00, flag}, 8'h00);
    results();
  end
endmodule
